// [common/sti_pkg.sv]
// package: register map, field layout and enumerations of the stage interrupt enable block
package sti_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int STAGES = 12;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_LOW_EN  = 10'h005;
	localparam logic [ADDR_W-1:0] ADDR_HIGH_EN = 10'h006;
	localparam logic [ADDR_W-1:0] ADDR_DONE_EN = 10'h007;

	// field positions
	localparam int POS_STAGE_LSB  = 0;
	localparam int POS_PIN_SETUP  = 12;
	localparam int POS_PIN_TRIG   = 14;
	localparam int POS_PIN_IRQ_EN = 12;

	// reset values
	localparam logic [STAGES-1:0] RST_STAGE_EN = 12'h000;
	localparam logic [1:0]        RST_FIELD2   = 2'h0;
	localparam logic              RST_BIT      = 1'b0;
	localparam logic [DATA_W-1:0] RST_RDATA    = 16'h0000;

	typedef enum logic [1:0] {
		PIN_OFF      = 2'h0,
		PIN_INPUT    = 2'h1,
		PIN_OUT_LOW  = 2'h2,
		PIN_OUT_HIGH = 2'h3
	} sti_pin_mode_e;

	typedef enum logic [1:0] {
		TRIG_LEVEL_LOW  = 2'h0,
		TRIG_RISE       = 2'h1,
		TRIG_FALL       = 2'h2,
		TRIG_LEVEL_HIGH = 2'h3
	} sti_pin_trig_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sti_reg_req_s;

	typedef struct packed {
		logic [STAGES-1:0] low;
		logic [STAGES-1:0] high;
		logic [STAGES-1:0] done;
	} sti_stage_evt_s;

endpackage

// [hw/sti_sync2.sv]
// module: two flip-flop synchroniser for one asynchronous level
module sti_sync2 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);
	logic meta_reg;

	// the first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// [hw/sti_irq_enable.sv]
// module: per-stage threshold interrupt enables, auxiliary pin setup and interrupt output
// Functional notes
// - bits 7..11 of the low-enable register let stage 7..11 low crossings interrupt.
// - a cleared enable blocks its source; all enables reset to zero.
// - pin-setup bits 13:12: 00 pin off, 01 pin is an input.
// - pin-setup 10 drives the pin active low, 11 drives it active high.
// - pin-setup 00 neither senses nor drives; it is the reset value.
// - trigger bits 15:14: low level, rising edge, falling edge, high level.
// - register 0x006 bits 0..11 are high enables by stage; 15:12 unused.
// - an enabled stage whose result exceeds its high threshold asserts interrupt.
// - low-enable register at 0x005; bits 0..6 are stages 0..6 low enables.
// - bit 12 of 0x007 lets the qualified pin input event assert interrupt.
module sti_irq_enable
	import sti_pkg::*;
#(
	parameter int NUM_STAGES = sti_pkg::STAGES
) (
	// clock and reset
	input  wire logic                   MCLK,
	input  wire logic                   RST,
	// register port from the serial interface
	input  wire sti_pkg::sti_reg_req_s  REG_REQ,
	output logic [sti_pkg::DATA_W-1:0]  REG_RDATA,
	output logic                        REG_RVALID,
	// stage threshold and completion conditions
	input  wire sti_pkg::sti_stage_evt_s STAGE_EVT,
	// clears a latched pin edge event
	input  wire logic                   PIN_EVT_CLR,
	// auxiliary pin
	input  wire logic                   GPIO_I,
	input  wire logic                   GPIO_DRIVE,
	output logic                        GPIO_O,
	output logic                        GPIO_OE_N,
	// active-low interrupt
	output logic                        INT_N
);

	// refused at elaboration: the register layout has room for twelve stages only
	if (NUM_STAGES < 1 || NUM_STAGES > STAGES) begin : g_bad_stages
		$error("NUM_STAGES must be 1 to 12");
	end

	logic [STAGES-1:0] low_en_reg;
	logic [STAGES-1:0] high_en_reg;
	logic [STAGES-1:0] done_en_reg;
	logic              pin_irq_en_reg;
	sti_pin_mode_e     pin_mode_reg;
	sti_pin_trig_e     pin_trig_reg;
	logic              pin_sync;
	logic              pin_prev_reg;
	logic              pin_edge_reg;
	logic              pin_edge_next;
	logic              pin_hit;
	logic              int_n_next;
	logic [STAGES-1:0] stage_mask;

	assign stage_mask = STAGES'((1 << NUM_STAGES) - 1);

	function automatic logic wr_hit(input sti_reg_req_s r, input logic [ADDR_W-1:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// low enables and pin configuration
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			low_en_reg   <= RST_STAGE_EN;
			pin_mode_reg <= PIN_OFF;
			pin_trig_reg <= TRIG_LEVEL_LOW;
		end else if (wr_hit(REG_REQ, ADDR_LOW_EN)) begin
			low_en_reg   <= REG_REQ.wdata[POS_STAGE_LSB +: STAGES] & stage_mask;
			pin_mode_reg <= sti_pin_mode_e'(REG_REQ.wdata[POS_PIN_SETUP +: 2]);
			pin_trig_reg <= sti_pin_trig_e'(REG_REQ.wdata[POS_PIN_TRIG +: 2]);
		end
	end

	// high enables; upper bits are not stored
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			high_en_reg <= RST_STAGE_EN;
		end else if (wr_hit(REG_REQ, ADDR_HIGH_EN)) begin
			high_en_reg <= REG_REQ.wdata[POS_STAGE_LSB +: STAGES] & stage_mask;
		end
	end

	// completion enables and pin interrupt enable
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			done_en_reg    <= RST_STAGE_EN;
			pin_irq_en_reg <= RST_BIT;
		end else if (wr_hit(REG_REQ, ADDR_DONE_EN)) begin
			done_en_reg    <= REG_REQ.wdata[POS_STAGE_LSB +: STAGES] & stage_mask;
			pin_irq_en_reg <= REG_REQ.wdata[POS_PIN_IRQ_EN];
		end
	end

	// register read back, one cycle after the request; unmapped reads zero
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			REG_RDATA  <= RST_RDATA;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_REQ.rd;
			if (REG_REQ.rd) begin
				case (REG_REQ.addr)
					ADDR_LOW_EN:  REG_RDATA <= {pin_trig_reg, pin_mode_reg, low_en_reg};
					ADDR_HIGH_EN: REG_RDATA <= {4'h0, high_en_reg};
					ADDR_DONE_EN: REG_RDATA <= {3'h0, pin_irq_en_reg, done_en_reg};
					default:      REG_RDATA <= RST_RDATA;
				endcase
			end
		end
	end

	// pin input is asynchronous, so it is synchronised before any use
	sti_sync2 u_pin_sync (
		.clk (MCLK),
		.rst (RST),
		.d   (GPIO_I),
		.q   (pin_sync)
	);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_sync;
		end
	end

	// edges latch until cleared; a new edge beats a clear in the same cycle
	always_comb begin
		pin_edge_next = pin_edge_reg;
		if (PIN_EVT_CLR) begin
			pin_edge_next = 1'b0;
		end
		if (pin_mode_reg == PIN_INPUT) begin
			if (pin_trig_reg == TRIG_RISE && pin_sync && !pin_prev_reg) begin
				pin_edge_next = 1'b1;
			end
			if (pin_trig_reg == TRIG_FALL && !pin_sync && pin_prev_reg) begin
				pin_edge_next = 1'b1;
			end
		end else begin
			pin_edge_next = 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pin_edge_reg <= 1'b0;
		end else begin
			pin_edge_reg <= pin_edge_next;
		end
	end

	// level triggers follow the pin; sensing only in input mode
	always_comb begin
		pin_hit = 1'b0;
		if (pin_mode_reg == PIN_INPUT && pin_irq_en_reg) begin
			case (pin_trig_reg)
				TRIG_LEVEL_LOW:  pin_hit = !pin_sync;
				TRIG_LEVEL_HIGH: pin_hit = pin_sync;
				TRIG_RISE:       pin_hit = pin_edge_reg;
				TRIG_FALL:       pin_hit = pin_edge_reg;
				default:         pin_hit = 1'b0;
			endcase
		end
	end

	// pin drive: enable is low while driving; off and input modes float
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			GPIO_O    <= 1'b0;
			GPIO_OE_N <= 1'b1;
		end else begin
			case (pin_mode_reg)
				PIN_OUT_LOW: begin
					GPIO_O    <= !GPIO_DRIVE;
					GPIO_OE_N <= 1'b0;
				end
				PIN_OUT_HIGH: begin
					GPIO_O    <= GPIO_DRIVE;
					GPIO_OE_N <= 1'b0;
				end
				default: begin
					GPIO_O    <= 1'b0;
					GPIO_OE_N <= 1'b1;
				end
			endcase
		end
	end

	// or of all enabled sources; disabled sources are masked out
	assign int_n_next = !(|(low_en_reg & STAGE_EVT.low)
		|| |(high_en_reg & STAGE_EVT.high)
		|| |(done_en_reg & STAGE_EVT.done)
		|| pin_hit);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			INT_N <= 1'b1;
		end else begin
			INT_N <= int_n_next;
		end
	end

endmodule

// [testbench/sti_irq_enable_sva.sv]
// checker: port-level assertions of the stage interrupt enable block
module sti_irq_enable_sva
	import sti_pkg::*;
#(
	parameter int NUM_STAGES = 12
) (
	input wire logic              MCLK,
	input wire logic              RST,
	input wire sti_reg_req_s      REG_REQ,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic              REG_RVALID,
	input wire sti_stage_evt_s    STAGE_EVT,
	input wire logic              PIN_EVT_CLR,
	input wire logic              GPIO_I,
	input wire logic              GPIO_DRIVE,
	input wire logic              GPIO_O,
	input wire logic              GPIO_OE_N,
	input wire logic              INT_N
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lo_reg, hi_reg, dn_reg, rd_exp;
	logic        pend, pin_on;
	// shadow copy of the enable words, so outputs are judged from port traffic alone
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			lo_reg <= 16'h0000;
			hi_reg <= 16'h0000;
			dn_reg <= 16'h0000;
		end else if (REG_REQ.wr) begin
			if (REG_REQ.addr == ADDR_LOW_EN) lo_reg <= REG_REQ.wdata;
			if (REG_REQ.addr == ADDR_HIGH_EN) hi_reg <= {4'h0, REG_REQ.wdata[11:0]};
			if (REG_REQ.addr == ADDR_DONE_EN) dn_reg <= {3'h0, REG_REQ.wdata[12:0]};
		end
	end
	always_comb begin
		case (REG_REQ.addr)
			ADDR_LOW_EN: rd_exp = lo_reg;
			ADDR_HIGH_EN: rd_exp = hi_reg;
			ADDR_DONE_EN: rd_exp = dn_reg;
			default: rd_exp = 16'h0000;
		endcase
	end
	assign pend = |{STAGE_EVT.low & lo_reg[11:0], STAGE_EVT.high & hi_reg[11:0],
		STAGE_EVT.done & dn_reg[11:0]};
	assign pin_on = lo_reg[13:12] == 2'h1 && dn_reg[12];
	chk_read_data: assert property (@(posedge MCLK) disable iff (RST)
		REG_REQ.rd |=> REG_RVALID && REG_RDATA == $past(rd_exp)) else $error("read data wrong");
	chk_rvalid_idle: assert property (@(posedge MCLK) disable iff (RST)
		!REG_REQ.rd |=> !REG_RVALID) else $error("read valid without read");
	chk_reset_state: assert property (@(posedge MCLK)
		RST |-> INT_N && GPIO_OE_N && REG_RDATA == 16'h0000) else $error("reset state wrong");
	chk_stage_irq: assert property (@(posedge MCLK) disable iff (RST)
		!pin_on [*3] |=> INT_N == !$past(pend)) else $error("interrupt level wrong");
	chk_pin_quiet: assert property (@(posedge MCLK) disable iff (RST)
		!lo_reg[13] |=> GPIO_OE_N) else $error("pin driven in off or input mode");
	chk_pin_drive: assert property (@(posedge MCLK) disable iff (RST)
		lo_reg[13] |=> !GPIO_OE_N && GPIO_O == ($past(GPIO_DRIVE) ~^ $past(lo_reg[12])))
		else $error("pin output wrong");
	chk_pin_level: assert property (@(posedge MCLK) disable iff (RST)
		(pin_on && lo_reg[15] == lo_reg[14] && GPIO_I == lo_reg[14]) [*4] |=> !INT_N)
		else $error("pin level missed");
	chk_pin_edge: assert property (@(posedge MCLK) disable iff (RST)
		pin_on && lo_reg[15] != lo_reg[14] && $changed(GPIO_I) && GPIO_I != lo_reg[15]
		##1 (pin_on && !PIN_EVT_CLR) [*5] |-> !INT_N) else $error("pin edge missed");
endmodule
bind sti_irq_enable sti_irq_enable_sva #(.NUM_STAGES(NUM_STAGES)) sti_irq_enable_sva_i (
	.MCLK(MCLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .STAGE_EVT(STAGE_EVT), .PIN_EVT_CLR(PIN_EVT_CLR),
	.GPIO_I(GPIO_I), .GPIO_DRIVE(GPIO_DRIVE), .GPIO_O(GPIO_O), .GPIO_OE_N(GPIO_OE_N),
	.INT_N(INT_N));

// [testbench/sti_host_model.sv]
// host model: register writes and reads over the strobe port
module sti_host_model
	import sti_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic [DATA_W-1:0] REG_RDATA,
	input  wire logic              REG_RVALID,
	output sti_reg_req_s           req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// a gap cycle after each strobe, so back-to-back calls never touch req twice at once
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge MCLK);
		req <= '{1'b1, 1'b0, a, (a == ADDR_HIGH_EN) ? {4'h0, d[11:0]} : d};
		@(negedge MCLK);
		req <= '0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
		@(negedge MCLK);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		// read valid stands for one cycle only, so the answer is taken before the strobe drops
		@(negedge MCLK);
		v = REG_RVALID;
		d = REG_RDATA;
		req <= '0;
	endtask
endmodule

// [testbench/sti_irq_enable_tb.sv]
// testbench: register, stage interrupt and auxiliary pin checks
module sti_irq_enable_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sti_pkg::*;
	logic              MCLK = 1'b0;
	logic              rst = 1'b0;
	sti_reg_req_s      req;
	sti_stage_evt_s    evt = '0;
	logic [DATA_W-1:0] rdata, d;
	logic              rvalid, v, gpio_o, oe_n, int_n;
	logic              clr = 1'b0;
	logic              gpio_i = 1'b0;
	logic              drive = 1'b0;
	int                mismatches = 0;
	int                tests_run = 0;
	int                cycles = 0;
	always #2 MCLK = ~MCLK;
	sti_host_model host (.MCLK(MCLK), .REG_RDATA(rdata), .REG_RVALID(rvalid), .req(req));
	sti_irq_enable sti_irq_enable_i (.MCLK(MCLK), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .STAGE_EVT(evt), .PIN_EVT_CLR(clr), .GPIO_I(gpio_i),
		.GPIO_DRIVE(drive), .GPIO_O(gpio_o), .GPIO_OE_N(oe_n), .INT_N(int_n));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
		host.rd(a, d, v);
		check({15'h0000, v}, 16'h0001);
		check(d, exp);
	endtask
	// the whole run needs a few hundred cycles; far beyond that means a hang
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		// a real rising edge on reset, so the asynchronous branch runs before the first clock
		#1 rst = 1'b1;
		repeat (6) @(negedge MCLK);
		rst = 1'b0;
		rdchk(ADDR_LOW_EN, 16'h0000);
		rdchk(ADDR_HIGH_EN, 16'h0000);
		rdchk(ADDR_DONE_EN, 16'h0000);
		host.wr(10'h004, 16'hffff);
		rdchk(10'h004, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			host.wr(ADDR_LOW_EN, 16'h0001 << i);
			host.wr(ADDR_HIGH_EN, 16'h0001 << i);
			host.wr(ADDR_DONE_EN, 16'h0001 << i);
			rdchk(ADDR_HIGH_EN, 16'h0001 << i);
			evt = ~{3{12'h001 << i}};
			repeat (2) @(negedge MCLK);
			check({15'h0000, int_n}, 16'h0001);
			for (int j = 0; j < 3; j++) begin
				evt = '0;
				evt[j*12 +: 12] = 12'h001 << i;
				repeat (2) @(negedge MCLK);
				check({15'h0000, int_n}, 16'h0000);
			end
		end
		evt = '0;
		for (int m = 0; m < 8; m++) begin
			host.wr(ADDR_LOW_EN, {2'h0, m[2:1], 12'h000});
			drive = m[0];
			repeat (2) @(negedge MCLK);
			if (m[2]) check({14'h0000, oe_n, gpio_o}, {15'h0000, m[0] ~^ m[1]});
			else check({15'h0000, oe_n}, 16'h0001);
		end
		host.wr(ADDR_DONE_EN, 16'h1000);
		for (int t = 0; t < 4; t++) begin
			host.wr(ADDR_LOW_EN, {t[1:0], 2'h1, 12'h000});
			gpio_i = !t[0];
			repeat (6) @(negedge MCLK);
			check({15'h0000, int_n}, 16'h0001);
			gpio_i = t[0];
			repeat (6) @(negedge MCLK);
			check({15'h0000, int_n}, 16'h0000);
			gpio_i = !t[0];
			repeat (6) @(negedge MCLK);
			check({15'h0000, int_n}, {15'h0000, t[0] ~^ t[1]});
			clr = 1'b1;
			@(negedge MCLK);
			clr = 1'b0;
			repeat (3) @(negedge MCLK);
			check({15'h0000, int_n}, 16'h0001);
		end
		host.wr(ADDR_LOW_EN, 16'h1000);
		gpio_i = 1'b0;
		host.wr(ADDR_DONE_EN, 16'h0000);
		repeat (6) @(negedge MCLK);
		check({15'h0000, int_n}, 16'h0001);
		summarize();
	end
endmodule
